//--- acp_pkg.sv
// acp_pkg: constants for the accelerometer configuration and power register group
// assumes a byte-wide register port with 8-bit addresses
package acp_pkg;
  localparam logic [7:0] ACP_ADDR_RANGE   = 8'h0F;
  localparam logic [7:0] ACP_ADDR_BW      = 8'h10;
  localparam logic [7:0] ACP_ADDR_LPW     = 8'h11;
  localparam logic [7:0] ACP_ADDR_LOWPWR  = 8'h12;
  localparam logic [7:0] ACP_ADDR_HBW     = 8'h13;
  localparam logic [7:0] ACP_ADDR_SRST    = 8'h14;
  localparam logic [3:0] ACP_RST_RANGE    = 4'h3;
  localparam logic [4:0] ACP_RST_BW       = 5'h0F;
  localparam logic [7:0] ACP_SRST_CODE    = 8'hB6;
  localparam logic [3:0] ACP_RANGE_2G     = 4'h3;
  localparam logic [3:0] ACP_RANGE_4G     = 4'h5;
  localparam logic [3:0] ACP_RANGE_8G     = 4'h8;
  localparam logic [3:0] ACP_RANGE_16G    = 4'hC;
  localparam int         ACP_LPW_SUSP_BIT = 7;
  localparam int         ACP_LPW_LP_BIT   = 6;
  localparam int         ACP_LPW_DEEP_BIT = 5;
  localparam int         ACP_LP_MODE_BIT  = 6;
  localparam int         ACP_LP_TBASE_BIT = 5;
  localparam int         ACP_HBW_UNF_BIT  = 7;
  localparam int         ACP_HBW_SHD_BIT  = 6;
  localparam int         ACP_CLK_MHZ      = 100;
  localparam int         ACP_SRST_DLY_US  = 2;
  localparam int         ACP_SRST_CYC     = ACP_SRST_DLY_US * ACP_CLK_MHZ;
  localparam int         ACP_US_CYC       = ACP_CLK_MHZ;
  localparam int         ACP_ACTIVE_US    = 100;
  localparam int         ACP_SLOW_WR_US   = 1;
  localparam int         ACP_SLOW_WR_CYC  = ACP_SLOW_WR_US * ACP_CLK_MHZ;
  typedef enum logic [4:0] {
    ACP_PWR_NORMAL  = 5'b00001,
    ACP_PWR_DEEP    = 5'b00010,
    ACP_PWR_DUTY    = 5'b00100,
    ACP_PWR_SUSPEND = 5'b01000,
    ACP_PWR_ILLEGAL = 5'b10000
  } acp_pwr_e;
  typedef enum logic [1:0] {
    ACP_DC_ACTIVE = 2'b01,
    ACP_DC_SLEEP  = 2'b10
  } acp_dc_e;
endpackage

//--- acp_shadow.sv
// acp_shadow: per-axis high-byte lock for coherent low/high reads
// assumes one-cycle read strobes per axis byte from the register port
module acp_shadow
  import acp_pkg::*;
#(
  parameter int AXES = 3
) (
  input  wire logic              mclk_i,
  input  wire logic              reset_i,
  input  wire logic              shadow_en_i,
  input  wire logic [AXES*8-1:0] live_msb_i,
  input  wire logic [AXES-1:0]   lsb_rd_i,
  input  wire logic [AXES-1:0]   msb_rd_i,
  output logic      [AXES*8-1:0] msb_o,
  output logic      [AXES-1:0]   locked_o
);
  logic [AXES-1:0]   lock_ff;
  logic [AXES*8-1:0] hold_ff;

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      lock_ff <= '0;
    end else begin
      for (int i = 0; i < AXES; i++) begin
        if (!shadow_en_i || msb_rd_i[i]) begin
          lock_ff[i] <= 1'b0; // [R14]
        end else if (lsb_rd_i[i]) begin
          lock_ff[i] <= 1'b1; // [R13]
        end
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      hold_ff <= '0;
    end else begin
      for (int i = 0; i < AXES; i++) begin
        if (!lock_ff[i]) begin
          hold_ff[i*8 +: 8] <= live_msb_i[i*8 +: 8]; // [R13]
        end
      end
    end
  end

  assign msb_o    = hold_ff;
  assign locked_o = lock_ff;
endmodule

//--- acp_regs.sv
// acp_regs: accelerometer range, bandwidth, power mode, output format and soft reset registers
// assumes a synchronous byte-wide register port: one-cycle write strobe, read data one cycle later
//
// Overview of operation
// R01: range field codes 0011, 0101, 1000, 1100 select 2, 4, 8, 16 g.
// R02: host writes only the four defined range codes.
// R03: bandwidth code 00xxx is 7.81 Hz, doubling upward, 1xxxx is 1000 Hz.
// R04: power triple decodes to normal, deepest sleep, duty-cycled, suspend or illegal.
// R05: host moves only between permitted power states.
// R06: sleep-duration code sets sleep length 0.5 ms up to 1 s.
// R07: lean sub-config drops FIFO in low states; host slows register writes.
// R08: FIFO-keeping sub-config keeps FIFO and full-speed writes.
// R09: time-base bit selects event-driven or equidistant timing in duty cycle.
// R10: evenly spaced FIFO entry only with equidistant time base.
// R11: unfiltered select bit chooses unfiltered or filtered output samples.
// R12: shadow-disable bit turns shadowing off; resets to one in 8-bit mode.
// R13: reading an axis low byte freezes its high byte.
// R14: reading the high byte releases the freeze.
// R15: writing 0xB6 to soft-reset starts a reset; other values ignored.
// R16: after a delay, all settings return to defaults.
// R17: soft-reset code accepted in every power state.
// R18: duty-cycled state alternates active phases and sleep phases.
module acp_regs
  import acp_pkg::*;
#(
  parameter int AXES       = 3,
  parameter int SRST_CYC   = ACP_SRST_CYC,
  parameter int ACTIVE_CYC = ACP_ACTIVE_US * ACP_US_CYC,
  parameter int US_CYC     = ACP_US_CYC
) (
  input  wire logic              mclk_i,
  input  wire logic              reset_i,
  input  wire logic              eight_bit_mode_i,
  input  wire logic              wr_en_i,
  input  wire logic              rd_en_i,
  input  wire logic [7:0]        addr_i,
  input  wire logic [7:0]        wdata_i,
  input  wire logic [AXES*8-1:0] live_msb_i,
  input  wire logic [AXES-1:0]   lsb_rd_i,
  input  wire logic [AXES-1:0]   msb_rd_i,
  output logic      [7:0]        rdata_o,
  output logic      [AXES*8-1:0] msb_o,
  output logic      [3:0]        range_o,
  output logic      [4:0]        filter_bandwidth_code_o,
  output logic      [4:0]        power_state_o,
  output logic                   sleep_phase_o,
  output logic                   sample_tick_o,
  output logic                   fifo_available_o,
  output logic                   wr_ready_o,
  output logic                   equidistant_o,
  output logic                   unfiltered_output_select_o,
  output logic                   shadow_en_o,
  output logic                   soft_reset_busy_o
);
  ////////////////////////////////////////////////////////////////////////////
  function automatic acp_pwr_e pwr_decode(input logic [2:0] t);
    case (t)
      3'b000:  pwr_decode = ACP_PWR_NORMAL;
      3'b001:  pwr_decode = ACP_PWR_DEEP;
      3'b010:  pwr_decode = ACP_PWR_DUTY;
      3'b100:  pwr_decode = ACP_PWR_SUSPEND;
      default: pwr_decode = ACP_PWR_ILLEGAL;
    endcase
  endfunction

  // sleep length in microseconds
  function automatic int sleep_us(input logic [3:0] c);
    case (c)
      4'h6:    sleep_us = 1000;
      4'h7:    sleep_us = 2000;
      4'h8:    sleep_us = 4000;
      4'h9:    sleep_us = 6000;
      4'hA:    sleep_us = 10000;
      4'hB:    sleep_us = 25000;
      4'hC:    sleep_us = 50000;
      4'hD:    sleep_us = 100000;
      4'hE:    sleep_us = 500000;
      4'hF:    sleep_us = 1000000;
      default: sleep_us = 500;
    endcase
  endfunction

  // sample period in clock cycles, from bandwidth code (odr = 2 x bw)
  function automatic int bw_period(input logic [4:0] c);
    int idx;
    idx = 0;
    if (c[4]) begin
      idx = 7;
    end else if (c[3]) begin
      idx = int'(c[2:0]);
    end
    bw_period = (64 * US_CYC) >> idx;
    if (bw_period < 1) begin
      bw_period = 1;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  logic [3:0]  range_ff;
  logic [4:0]  bw_ff;
  logic [2:0]  pwr_ff;
  logic [3:0]  sleep_dur_ff;
  logic        lp_mode_ff;
  logic        tbase_ff;
  logic        unf_ff;
  logic        shd_dis_ff;
  logic        srst_busy_ff;
  logic [31:0] srst_cnt_ff;
  logic        cfg_rst;
  logic        wr_hit;
  logic [31:0] slow_cnt_ff;
  logic        wr_ready_ff;
  acp_pwr_e    pwr_state;
  logic        low_state;
  logic [7:0]  rdata_ff;
  logic [7:0]  nxt_rdata;

  assign pwr_state = pwr_decode(pwr_ff); // [R04]
  assign low_state = (pwr_state == ACP_PWR_DUTY) || (pwr_state == ACP_PWR_SUSPEND);
  assign cfg_rst   = reset_i || (srst_busy_ff && srst_cnt_ff == 32'd0);
  assign wr_hit    = wr_en_i && wr_ready_ff && !srst_busy_ff;

  ////////////////////////////////////////////////////////////////////////////
  // configuration registers
  always_ff @(posedge mclk_i) begin
    if (cfg_rst) begin // [R16]
      range_ff     <= ACP_RST_RANGE;
      bw_ff        <= ACP_RST_BW;
      pwr_ff       <= 3'h0;
      sleep_dur_ff <= 4'h0;
      lp_mode_ff   <= 1'b0;
      tbase_ff     <= 1'b0;
      unf_ff       <= 1'b0;
      shd_dis_ff   <= eight_bit_mode_i; // [R12]
    end else if (wr_hit) begin
      case (addr_i)
        ACP_ADDR_RANGE:  range_ff <= wdata_i[3:0]; // [R01]
        ACP_ADDR_BW:     bw_ff <= wdata_i[4:0]; // [R03]
        ACP_ADDR_LPW: begin
          pwr_ff       <= {wdata_i[ACP_LPW_SUSP_BIT], wdata_i[ACP_LPW_LP_BIT], wdata_i[ACP_LPW_DEEP_BIT]};
          sleep_dur_ff <= wdata_i[4:1]; // [R06]
        end
        ACP_ADDR_LOWPWR: begin
          lp_mode_ff <= wdata_i[ACP_LP_MODE_BIT];
          tbase_ff   <= wdata_i[ACP_LP_TBASE_BIT]; // [R09]
        end
        ACP_ADDR_HBW: begin
          unf_ff     <= wdata_i[ACP_HBW_UNF_BIT]; // [R11]
          shd_dis_ff <= wdata_i[ACP_HBW_SHD_BIT]; // [R12]
        end
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // soft reset command, taken in any power state
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      srst_busy_ff <= 1'b0;
      srst_cnt_ff  <= 32'd0;
    end else if (srst_busy_ff) begin
      if (srst_cnt_ff == 32'd0) begin
        srst_busy_ff <= 1'b0;
      end else begin
        srst_cnt_ff <= srst_cnt_ff - 32'd1; // [R16]
      end
    end else if (wr_en_i && addr_i == ACP_ADDR_SRST && wdata_i == ACP_SRST_CODE) begin // [R15] [R17]
      srst_busy_ff <= 1'b1;
      srst_cnt_ff  <= 32'(SRST_CYC - 1);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // write pacing in lean sub-config low states
  always_ff @(posedge mclk_i) begin
    if (cfg_rst) begin
      slow_cnt_ff <= 32'd0;
      wr_ready_ff <= 1'b1;
    end else if (wr_hit && low_state && !lp_mode_ff) begin // [R07]
      slow_cnt_ff <= 32'(ACP_SLOW_WR_CYC - 1);
      wr_ready_ff <= 1'b0;
    end else if (slow_cnt_ff != 32'd0) begin
      slow_cnt_ff <= slow_cnt_ff - 32'd1;
    end else begin
      wr_ready_ff <= 1'b1; // [R08]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // duty cycle sequencer and sample tick
  acp_dc_e     dc_ff;
  logic [31:0] dc_cnt_ff;
  logic [31:0] smp_cnt_ff;
  logic        tick_ff;
  logic [31:0] sleep_cyc;
  assign sleep_cyc = 32'(sleep_us(sleep_dur_ff) * US_CYC);

  always_ff @(posedge mclk_i) begin
    if (cfg_rst || pwr_state != ACP_PWR_DUTY) begin
      dc_ff     <= ACP_DC_ACTIVE;
      dc_cnt_ff <= 32'(ACTIVE_CYC - 1);
    end else begin
      case (dc_ff)
        ACP_DC_ACTIVE: begin
          if (dc_cnt_ff == 32'd0) begin
            dc_ff     <= ACP_DC_SLEEP; // [R18]
            dc_cnt_ff <= sleep_cyc - 32'd1; // [R06]
          end else begin
            dc_cnt_ff <= dc_cnt_ff - 32'd1;
          end
        end
        ACP_DC_SLEEP: begin
          if (dc_cnt_ff == 32'd0) begin
            dc_ff     <= ACP_DC_ACTIVE; // [R18]
            dc_cnt_ff <= 32'(ACTIVE_CYC - 1);
          end else begin
            dc_cnt_ff <= dc_cnt_ff - 32'd1;
          end
        end
        default: begin
          dc_ff     <= ACP_DC_ACTIVE;
          dc_cnt_ff <= 32'd0;
        end
      endcase
    end
  end

  // equidistant base keeps its sample grid through sleep; event base restarts on wake
  always_ff @(posedge mclk_i) begin
    if (cfg_rst) begin
      smp_cnt_ff <= 32'd0;
      tick_ff    <= 1'b0;
    end else begin
      tick_ff <= 1'b0;
      if (pwr_state == ACP_PWR_DUTY && !tbase_ff && dc_ff == ACP_DC_SLEEP) begin
        smp_cnt_ff <= 32'd0; // [R09]
      end else if (smp_cnt_ff == 32'd0) begin
        smp_cnt_ff <= 32'(bw_period(bw_ff) - 1); // [R03] [R10]
        tick_ff    <= (pwr_state == ACP_PWR_NORMAL) ||
                      (pwr_state == ACP_PWR_DUTY && dc_ff == ACP_DC_ACTIVE);
      end else begin
        smp_cnt_ff <= smp_cnt_ff - 32'd1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read back
  always_comb begin
    nxt_rdata = 8'h00;
    case (addr_i)
      ACP_ADDR_RANGE:  nxt_rdata = {4'h0, range_ff};
      ACP_ADDR_BW:     nxt_rdata = {3'h0, bw_ff};
      ACP_ADDR_LPW:    nxt_rdata = {pwr_ff, sleep_dur_ff, 1'b0};
      ACP_ADDR_LOWPWR: nxt_rdata = {1'b0, lp_mode_ff, tbase_ff, 5'h00};
      ACP_ADDR_HBW:    nxt_rdata = {unf_ff, shd_dis_ff, 6'h00};
      default:         nxt_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      rdata_ff <= 8'h00;
    end else if (rd_en_i) begin
      rdata_ff <= nxt_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registered outputs
  logic [4:0] pwr_o_ff;
  logic       sleep_o_ff;
  logic       fifo_o_ff;
  always_ff @(posedge mclk_i) begin
    if (cfg_rst) begin
      pwr_o_ff   <= ACP_PWR_NORMAL;
      sleep_o_ff <= 1'b0;
      fifo_o_ff  <= 1'b1;
    end else begin
      pwr_o_ff   <= pwr_state;
      sleep_o_ff <= (pwr_state == ACP_PWR_DUTY) && (dc_ff == ACP_DC_SLEEP);
      fifo_o_ff  <= !(low_state && !lp_mode_ff); // [R07] [R08]
    end
  end

  acp_shadow #(.AXES(AXES)) u_shadow (
    .mclk_i      (mclk_i),
    .reset_i     (cfg_rst),
    .shadow_en_i (!shd_dis_ff), // [R12]
    .live_msb_i  (live_msb_i),
    .lsb_rd_i    (lsb_rd_i),
    .msb_rd_i    (msb_rd_i),
    .msb_o       (msb_o),
    .locked_o    ()
  );

  assign rdata_o                    = rdata_ff;
  assign range_o                    = range_ff;
  assign filter_bandwidth_code_o    = bw_ff;
  assign power_state_o              = pwr_o_ff;
  assign sleep_phase_o              = sleep_o_ff;
  assign sample_tick_o              = tick_ff;
  assign fifo_available_o           = fifo_o_ff;
  assign wr_ready_o                 = wr_ready_ff;
  assign equidistant_o              = tbase_ff;
  assign unfiltered_output_select_o = unf_ff; // [R11]
  assign shadow_en_o                = !shd_dis_ff;
  assign soft_reset_busy_o          = srst_busy_ff;
endmodule

//--- acp_host_model.sv
// acp_host_model: host side of the byte-wide register port
// assumes writes on a one-cycle strobe and read data one cycle after the read edge
module acp_host_model (
  input  wire logic       mclk_i,
  input  wire logic       wr_ready_i,
  input  wire logic [7:0] rdata_i,
  output logic            wr_en_o,
  output logic            rd_en_o,
  output logic      [7:0] addr_o,
  output logic      [7:0] wdata_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    wr_en_o = 1'b0;
    rd_en_o = 1'b0;
    addr_o  = 8'h00;
    wdata_o = 8'h00;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // write, paced by ready unless pace is clear
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input bit pace);
    int n;
    n = 0;
    @(posedge mclk_i);
    #1;
    while (pace && wr_ready_i !== 1'b1 && n < 500) begin
      @(posedge mclk_i);
      #1;
      n++;
    end
    wr_en_o <= 1'b1;
    addr_o  <= a;
    wdata_o <= d;
    @(posedge mclk_i);
    #1;
    wr_en_o <= 1'b0;
    addr_o  <= ~a;
    wdata_o <= ~d;
    #1;
    @(posedge mclk_i);
    #1;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk_i);
    #1;
    rd_en_o <= 1'b1;
    addr_o  <= a;
    @(posedge mclk_i);
    #1;
    rd_en_o <= 1'b0;
    addr_o  <= ~a;
    @(posedge mclk_i);
    #1;
    d = rdata_i;
  endtask
endmodule

//--- acp_regs_props.sv
// acp_regs_props: port checks of the configuration register group
// assumes binding onto acp_regs, one clock, synchronous reset
module acp_regs_props
  import acp_pkg::*;
#(
  parameter int AXES = 3
) (
  input wire logic              mclk_i,
  input wire logic              reset_i,
  input wire logic              wr_en_i,
  input wire logic [7:0]        addr_i,
  input wire logic [7:0]        wdata_i,
  input wire logic [AXES*8-1:0] live_msb_i,
  input wire logic [AXES-1:0]   lsb_rd_i,
  input wire logic [AXES-1:0]   msb_rd_i,
  input wire logic [AXES*8-1:0] msb_o,
  input wire logic [3:0]        range_o,
  input wire logic [4:0]        filter_bandwidth_code_o,
  input wire logic [4:0]        power_state_o,
  input wire logic              fifo_available_o,
  input wire logic              wr_ready_o,
  input wire logic              unfiltered_output_select_o,
  input wire logic              shadow_en_o,
  input wire logic              soft_reset_busy_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (reset_i);
  logic acc;
  assign acc = wr_en_i && wr_ready_o && !soft_reset_busy_o;
  function automatic logic [4:0] dec(input logic [2:0] t);
    case (t)
      3'b000:  return 5'h01;
      3'b001:  return 5'h02;
      3'b010:  return 5'h04;
      3'b100:  return 5'h08;
      default: return 5'h10;
    endcase
  endfunction
  ////////////////////////////////////////////////////////////////////////////////
  a_range_write: assert property (acc && addr_i == 8'h0F |=> range_o == $past(wdata_i[3:0]))
    else $error("range field not taken from write");
  a_bw_write: assert property (acc && addr_i == 8'h10 |=> filter_bandwidth_code_o == $past(wdata_i[4:0]))
    else $error("bandwidth field not taken from write");
  a_power_decode: assert property (acc && addr_i == 8'h11 |=>
    ##1 power_state_o == dec($past(wdata_i[7:5], 2)))
    else $error("power state decode wrong");
  a_format_write: assert property (acc && addr_i == 8'h13 |=>
    unfiltered_output_select_o == $past(wdata_i[7]) && shadow_en_o == !$past(wdata_i[6]))
    else $error("output format bits wrong");
  a_srst_start: assert property (wr_en_i && addr_i == 8'h14 && !soft_reset_busy_o |=>
    soft_reset_busy_o == ($past(wdata_i) == 8'hB6))
    else $error("soft reset start wrong");
  a_srst_bound: assert property ($rose(soft_reset_busy_o) |-> ##[1:300] !soft_reset_busy_o)
    else $error("soft reset never completes");
  a_srst_defaults: assert property ($fell(soft_reset_busy_o) |-> range_o == 4'h3
    && filter_bandwidth_code_o == 5'h0F && power_state_o == 5'h01)
    else $error("defaults not restored");
  a_fifo_gone: assert property (!fifo_available_o |-> power_state_o == 5'h04 || power_state_o == 5'h08)
    else $error("fifo dropped in wrong state");
  a_shadow_hold: assert property ((shadow_en_o && lsb_rd_i[0] && !msb_rd_i[0]) ##1 (!msb_rd_i[0])[*3]
    |-> msb_o[7:0] == $past(msb_o[7:0]))
    else $error("locked high byte moved");
  a_msb_follow: assert property (!shadow_en_o && $past(!shadow_en_o) && $past(!reset_i)
    |-> msb_o[7:0] == $past(live_msb_i[7:0]))
    else $error("high byte not following");
endmodule
bind acp_regs acp_regs_props #(.AXES(AXES)) u_acp_regs_props (.mclk_i, .reset_i, .wr_en_i, .addr_i, .wdata_i,
  .live_msb_i, .lsb_rd_i, .msb_rd_i, .msb_o, .range_o, .filter_bandwidth_code_o, .power_state_o, .fifo_available_o,
  .wr_ready_o, .unfiltered_output_select_o, .shadow_en_o, .soft_reset_busy_o);

//--- accel_config_power_regs_tb.sv
// accel_config_power_regs_tb: self-checking bench of the register group
// assumes acp_regs with shortened counts and the host model driving its port
module accel_config_power_regs_tb;
  import acp_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic        mclk_i = 1'b0;
  logic        reset_i = 1'b1;
  logic        eight_bit_mode_i = 1'b0;
  logic [23:0] live_msb_i = 24'h0;
  logic [2:0]  lsb_rd_i = 3'h0;
  logic [2:0]  msb_rd_i = 3'h0;
  logic        wr_en, rd_en, sleep, tick, fifo, wr_ready, equi, unf, shd, busy;
  logic [7:0]  addr, wdata, rdata, v;
  logic [23:0] msb;
  logic [3:0]  range;
  logic [4:0]  bw, pwr;
  int          bad_count = 0;
  int          cmp_count = 0;
  int          n;
  // rows: address, write data, expected read back
  logic [23:0] rows [14] = '{24'h0F0505, 24'h0F0808, 24'h0F0C0C, 24'h0FF303, 24'h101F1F, 24'h10E808,
    24'h115E5E, 24'h110000, 24'h126060, 24'h129F00, 24'h13C0C0, 24'h133F00, 24'h140000, 24'h20FF00};
  always #5 mclk_i = ~mclk_i;
  always @(posedge mclk_i) live_msb_i <= live_msb_i + 24'h010101;
  acp_host_model u_acp_host_model (.mclk_i(mclk_i), .wr_ready_i(wr_ready), .rdata_i(rdata), .wr_en_o(wr_en),
    .rd_en_o(rd_en), .addr_o(addr), .wdata_o(wdata));
  acp_regs #(.SRST_CYC(5), .ACTIVE_CYC(10), .US_CYC(1)) u_acp_regs (.mclk_i(mclk_i), .reset_i(reset_i),
    .eight_bit_mode_i(eight_bit_mode_i), .wr_en_i(wr_en), .rd_en_i(rd_en), .addr_i(addr), .wdata_i(wdata),
    .live_msb_i(live_msb_i), .lsb_rd_i(lsb_rd_i), .msb_rd_i(msb_rd_i), .rdata_o(rdata), .msb_o(msb),
    .range_o(range), .filter_bandwidth_code_o(bw), .power_state_o(pwr), .sleep_phase_o(sleep),
    .sample_tick_o(tick), .fifo_available_o(fifo), .wr_ready_o(wr_ready), .equidistant_o(equi),
    .unfiltered_output_select_o(unf), .shadow_en_o(shd), .soft_reset_busy_o(busy));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask
  task automatic close_out;
    $display("compares=%0d mismatches=%0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  function automatic logic [4:0] exp_pwr(input int t);
    case (t)
      0:       return 5'h01;
      1:       return 5'h02;
      2:       return 5'h04;
      4:       return 5'h08;
      default: return 5'h10;
    endcase
  endfunction
  initial begin
    repeat (20000) @(posedge mclk_i);
    bad_count++;
    close_out();
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(posedge mclk_i);
    reset_i <= 1'b0;
    foreach (rows[i]) begin
      u_acp_host_model.wr(rows[i][23:16], rows[i][15:8], 1'b1);
      if (rows[i][23:16] == 8'h0F) chk(range, rows[i][3:0]);
      u_acp_host_model.rd(rows[i][23:16], v);
      chk(v, rows[i][7:0]);
    end
    @(posedge mclk_i) reset_i <= 1'b1;
    repeat (4) @(posedge mclk_i);
    reset_i <= 1'b0;
    #1;
    chk({range, bw, pwr, shd, wr_ready, fifo}, {4'h3, 5'h0F, 5'h01, 3'b111});
    for (int t = 0; t < 8; t++) begin
      u_acp_host_model.wr(8'h11, 8'(t << 5), 1'b1);
      chk(pwr, exp_pwr(t));
    end
    // lean sub-config in suspend: fifo gone, writes paced
    u_acp_host_model.wr(8'h11, 8'h80, 1'b1);
    chk(fifo, 1'b0);
    u_acp_host_model.wr(8'h0F, 8'h05, 1'b1);
    u_acp_host_model.wr(8'h0F, 8'h0C, 1'b0);
    chk(wr_ready, 1'b0);
    u_acp_host_model.rd(8'h0F, v);
    chk(v, 8'h05);
    u_acp_host_model.wr(8'h12, 8'h40, 1'b1);
    chk(fifo, 1'b1);
    u_acp_host_model.wr(8'h0F, 8'h0C, 1'b1);
    chk({wr_ready, range}, {1'b1, 4'hC});
    // soft reset from suspend
    eight_bit_mode_i <= 1'b1;
    u_acp_host_model.wr(8'h14, 8'h55, 1'b0);
    chk(busy, 1'b0);
    u_acp_host_model.wr(8'h14, 8'hB6, 1'b0);
    chk(busy, 1'b1);
    n = 0;
    while (busy === 1'b1 && n < 50) begin
      @(posedge mclk_i);
      #1;
      n++;
    end
    chk({range, bw, pwr, shd}, {4'h3, 5'h0F, 5'h01, 1'b0});
    // duty cycle with equidistant time base and shortest sleep
    u_acp_host_model.wr(8'h12, 8'h60, 1'b1);
    chk(equi, 1'b1);
    u_acp_host_model.wr(8'h11, 8'h40, 1'b1);
    n = 0;
    while (sleep !== 1'b1 && n < 200) begin
      @(posedge mclk_i);
      #1;
      n++;
    end
    chk(pwr, 5'h04);
    n = 0;
    while (sleep === 1'b1 && n < 2000) begin
      @(posedge mclk_i);
      #1;
      n++;
    end
    chk(n, 500);
    u_acp_host_model.wr(8'h11, 8'h00, 1'b1);
    // sample tick spacing in normal mode at the lowest bandwidth
    u_acp_host_model.wr(8'h10, 8'h08, 1'b1);
    n = 0;
    while (tick !== 1'b1 && n < 100) begin
      @(posedge mclk_i);
      #1;
      n++;
    end
    n = 1;
    @(posedge mclk_i);
    #1;
    while (tick !== 1'b1 && n < 200) begin
      @(posedge mclk_i);
      #1;
      n++;
    end
    chk(n, 64);
    // high byte lock and release
    u_acp_host_model.wr(8'h13, 8'h00, 1'b1);
    @(posedge mclk_i) lsb_rd_i <= 3'b001;
    @(posedge mclk_i) lsb_rd_i <= 3'b000;
    repeat (3) @(posedge mclk_i);
    #1;
    v = msb[7:0];
    repeat (4) @(posedge mclk_i);
    #1;
    chk(msb[7:0], v);
    @(posedge mclk_i) msb_rd_i <= 3'b001;
    @(posedge mclk_i) msb_rd_i <= 3'b000;
    repeat (3) @(posedge mclk_i);
    #1;
    chk(msb[7:0], live_msb_i[7:0] - 8'h01);
    close_out();
  end
endmodule
